// *** hdl/nbs_pkg.sv ***
// Constants and types shared by the nine-bit serial port and its rate generator.
// Assumes one 100 MHz clock and a 32-bit classic Wishbone register bus.
//
// How it works
// RQ1: Frame is start, nine data LSB-first, stop.
// RQ2: Fixed nine-bit rate is clock/64 or clock/32.
// RQ3: Transmitted ninth bit comes from control field.
// RQ4: Buffer write starts a frame, LSB first.
// RQ5: Transmit flag sets at stop bit start.
// RQ6: Enabled receiver starts on start-bit falling edge.
// RQ7: Receive flag sets at middle of stop.
// RQ8: Low byte to buffer, ninth to status.
// RQ9: Source select: timer overflow or reload generator.
// RQ10: Rate-double doubles the selected variable source.
// RQ11: Generator rate is clock/(64*(1024-reload)), doubled.
// RQ12: Timer rate is overflows/(32*(256-reload)), doubled.
// RQ13: Software keeps timer reload at most 0xFB.
// RQ14: Clock must exceed four times overflow rate.
// RQ15: Multiprocessor mode flags only ninth-bit-one frames.
// RQ16: Master sends address ninth=1, data ninth=0.
// RQ17: Matching slave clears multiprocessor enable bit.
// RQ18: Port disabled halts clocks, blocks register access.
// RQ19: Software sets port enable before other setup.
// RQ20: Done flags stay set until software clears.
// RQ21: Pin select chooses first or second pin pair.
// RQ22: Software keeps receive pin out of open-drain.
// RQ23: Shift-register mode runs at clock/12.
// RQ24: Done flags readable by polling without interrupts.
// RQ25: Transmit pin is only ever pulled low.
// RQ26: Mode field: shift, var8, fixed9, var9.

package nbs_pkg;

  // -------------------------------------------------------------------
  // Register indices (byte address is four times the index).
  // -------------------------------------------------------------------
  localparam logic [7:0] NBS_IDX_PWR  = 8'h87;
  localparam logic [7:0] NBS_IDX_CTRL = 8'h98;
  localparam logic [7:0] NBS_IDX_BUF  = 8'h99;
  localparam logic [7:0] NBS_IDX_IEN  = 8'hA8;
  localparam logic [7:0] NBS_IDX_RELL = 8'hAA;
  localparam logic [7:0] NBS_IDX_RELH = 8'hBA;
  localparam logic [7:0] NBS_IDX_CTL2 = 8'hD8;
  localparam logic [7:0] NBS_IDX_OD   = 8'hE4;

  // -------------------------------------------------------------------
  // Field positions.
  // -------------------------------------------------------------------
  localparam int NBS_B_MODE_HI = 7;
  localparam int NBS_B_MODE_LO = 6;
  localparam int NBS_B_MPE     = 5;
  localparam int NBS_B_PEN     = 4;
  localparam int NBS_B_TB8     = 3;
  localparam int NBS_B_RB8     = 2;
  localparam int NBS_B_TI      = 1;
  localparam int NBS_B_RI      = 0;
  localparam int NBS_B_RATE_DOUBLE    = 7;
  localparam int NBS_B_SRC     = 7;
  localparam int NBS_B_PINSEL  = 0;
  localparam int NBS_B_IE_G    = 7;
  localparam int NBS_B_IE_RX   = 5;
  localparam int NBS_B_IE_TX   = 4;

  // -------------------------------------------------------------------
  // Reset values and cycle counts.
  // -------------------------------------------------------------------
  localparam logic [7:0] NBS_RST_BYTE   = 8'h00;
  localparam logic [9:0] NBS_RST_REL    = 10'h000;
  localparam int         NBS_OVERSAMPLE = 16;
  localparam int         NBS_FIX_DIV    = 64;
  localparam int         NBS_SHIFT_DIV  = 12;
  localparam logic [3:0] NBS_TICK_LAST  = 4'(NBS_OVERSAMPLE - 1);
  localparam logic [3:0] NBS_TICK_MID   = 4'(NBS_OVERSAMPLE / 2 - 1);
  localparam logic [3:0] NBS_PRE_SLOW   = 4'(NBS_FIX_DIV / NBS_OVERSAMPLE - 1);
  localparam logic [3:0] NBS_PRE_FAST   = 4'(NBS_FIX_DIV / NBS_OVERSAMPLE / 2 - 1);
  localparam logic [3:0] NBS_PRE_SHIFT  = 4'(NBS_SHIFT_DIV - 1);
  localparam logic [9:0] NBS_REL_TOP    = 10'h3FF;

  // -------------------------------------------------------------------
  // Types.
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {NBS_SHIFT, NBS_VAR8, NBS_FIX9, NBS_VAR9} nbs_mode_e;

  // Rate generator configuration.
  typedef struct packed {
    logic      run;
    nbs_mode_e mode;
    logic      rate_double;
    logic      src;
    logic [9:0] reload;
  } nbs_rate_cfg_s;

endpackage

// *** hdl/nbs_rate_gen.sv ***
// Bit-rate tick generator of the nine-bit serial port.
// Assumes a timer overflow pulse on the same clock, one cycle wide.

`timescale 1ns/10ps
`default_nettype none

module nbs_rate_gen (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire nbs_pkg::nbs_rate_cfg_s cfg_i,
  input  wire logic              timer_ovf_i,
  output logic                   tick_o
);
  import nbs_pkg::*;

  // -------------------------------------------------------------------
  // State.
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] pre;   // Clock prescaler.
    logic [9:0] div;   // Reload divider count.
    logic       half;  // Overflow halving toggle.
    logic       tick;  // Sixteenth-of-bit tick (one per bit in shift mode).
  } nbs_rg_s;

  nbs_rg_s s;
  nbs_rg_s next_s;

  // Prescale limit for sixteen ticks per bit at clock/64 or clock/32.
  function automatic logic [3:0] pre_lim(input logic rate_double);
    return rate_double ? NBS_PRE_FAST : NBS_PRE_SLOW;
  endfunction

  // -------------------------------------------------------------------
  // Next state.
  // -------------------------------------------------------------------
  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (!cfg_i.run) begin
      // Clock gating: nothing counts while the port is off.
      next_s.pre  = '0; // RQ18
      next_s.div  = cfg_i.reload;
      next_s.half = 1'b0;
    end else begin
      // Outside the reload source the divider waits at the reload value, so
      // the first tick after a switch is not a whole ten-bit wrap late.
      if (!(cfg_i.src && cfg_i.mode inside {NBS_VAR8, NBS_VAR9})) begin
        next_s.div = cfg_i.reload;
      end
      unique case (cfg_i.mode)
        NBS_SHIFT: begin
          // One tick is one whole bit here.
          if (s.pre == NBS_PRE_SHIFT) begin // RQ23
            next_s.pre  = '0;
            next_s.tick = 1'b1;
          end else begin
            next_s.pre = s.pre + 4'h1;
          end
        end
        NBS_FIX9: begin
          if (s.pre >= pre_lim(cfg_i.rate_double)) begin // RQ2
            next_s.pre  = '0;
            next_s.tick = 1'b1;
          end else begin
            next_s.pre = s.pre + 4'h1;
          end
        end
        NBS_VAR8, NBS_VAR9: begin
          if (cfg_i.src) begin // RQ9
            // Divider walks reload..top, so its period is 1024-reload steps.
            if (s.pre >= pre_lim(cfg_i.rate_double)) begin // RQ10 RQ11
              next_s.pre = '0;
              if (s.div == NBS_REL_TOP) begin
                next_s.div  = cfg_i.reload;
                next_s.tick = 1'b1;
              end else begin
                next_s.div = s.div + 10'h001;
              end
            end else begin
              next_s.pre = s.pre + 4'h1;
            end
          end else if (timer_ovf_i) begin
            // Two overflows per tick, or one when doubled.
            next_s.tick = cfg_i.rate_double | s.half; // RQ12
            next_s.half = ~s.half & ~cfg_i.rate_double;
          end
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // State register.
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;

endmodule

`default_nettype wire

// *** hdl/nbs_serial_port.sv ***
// Nine-bit asynchronous serial port with Wishbone register access.
// Assumes a classic Wishbone master, raw serial input pins from outside
// the clock domain, and an external port latch that keeps the transmit
// pin high except where this block pulls it low.
//
// Implementation choice: the Wishbone slave port.

`timescale 1ns/10ps
`default_nettype none

module nbs_serial_port (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:2]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        timer_ovf_i,
  input  wire logic        serial_in_a_i,
  input  wire logic        serial_in_b_i,
  output logic             serial_out_a_low_o,
  output logic             serial_out_b_low_o,
  output logic      [3:0]  open_drain_sel_o,
  output logic             rx_irq_req_o,
  output logic             tx_irq_req_o
);
  import nbs_pkg::*;

  // -------------------------------------------------------------------
  // State.
  // -------------------------------------------------------------------
  typedef enum logic {NBS_RX_IDLE, NBS_RX_RUN} nbs_rx_e;

  typedef struct packed {
    logic       ack;      // Bus acknowledge.
    logic [7:0] rdat;     // Registered read data.
    nbs_mode_e  mode;     // Operating mode.
    logic       mpe;      // Multiprocessor enable.
    logic       pen;      // Port enable.
    logic       tb8;      // Ninth bit to send.
    logic       rb8;      // Ninth bit received.
    logic       ti;       // Transmit done flag.
    logic       ri;       // Receive done flag.
    logic       rate_double;     // Rate double.
    logic       src;      // Rate source select.
    logic       pinsel;   // Pin pair select.
    logic [9:0] rel;      // Reload value.
    logic       ie_g;     // Global interrupt enable.
    logic       ie_rx;    // Receive interrupt enable.
    logic       ie_tx;    // Transmit interrupt enable.
    logic [3:0] od;       // Open-drain selects.
    logic [7:0] rbuf;     // Received byte.
    logic       tx_busy;  // Frame in flight.
    logic [10:0] tx_sh;   // Transmit shifter, LSB on the line.
    logic [3:0] tx_bit;   // Index of bit on the line.
    logic [3:0] tx_tk;    // Ticks into the bit.
    nbs_rx_e    rx_st;    // Receiver state.
    logic [8:0] rx_sh;    // Receive shifter, fills from the top.
    logic [3:0] rx_bit;   // Index of bit being received.
    logic [3:0] rx_tk;    // Ticks into the bit.
    logic       sa1;      // Pin A synchroniser, first stage.
    logic       sa2;      // Pin A synchroniser, second stage.
    logic       sb1;      // Pin B synchroniser, first stage.
    logic       sb2;      // Pin B synchroniser, second stage.
    logic       rx_prev;  // Previous selected line level.
    logic       out_a_low; // Pull pin A low.
    logic       out_b_low; // Pull pin B low.
    logic       rx_req;   // Receive interrupt request.
    logic       tx_req;   // Transmit interrupt request.
  } nbs_state_s;

  nbs_state_s    s;
  nbs_state_s    next_s;
  nbs_rate_cfg_s rate_cfg;  // Rate generator setup.
  logic          tick;      // Rate tick.

  // Index of the last bit of a frame: the stop bit, or bit 7 in shift mode.
  function automatic logic [3:0] last_bit(input nbs_mode_e m);
    unique case (m)
      NBS_SHIFT: return 4'd7;
      NBS_VAR8:  return 4'd9;
      NBS_FIX9,
      NBS_VAR9:  return 4'd10; // RQ1
    endcase
  endfunction

  // -------------------------------------------------------------------
  // Rate generator.
  // -------------------------------------------------------------------
  assign rate_cfg = '{run: s.pen, mode: s.mode, rate_double: s.rate_double, src: s.src, reload: s.rel};

  nbs_rate_gen u_rate (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .cfg_i       (rate_cfg),
    .timer_ovf_i (timer_ovf_i),
    .tick_o      (tick)
  );

  // -------------------------------------------------------------------
  // Next state: bus, registers, transmitter, receiver, pins.
  // -------------------------------------------------------------------
  always_comb begin
    logic       req;
    logic       wr;
    logic       blk;
    logic [7:0] d;
    logic [3:0] tpb;
    logic       line;
    logic       ninth;
    req   = 1'b0;
    wr    = 1'b0;
    blk   = 1'b0;
    d     = 8'h00;
    tpb   = 4'h0;
    line  = 1'b1;
    ninth = 1'b0;
    next_s = s;

    // Two-stage synchronisers on both receive pins.
    next_s.sa1 = serial_in_a_i;
    next_s.sa2 = s.sa1;
    next_s.sb1 = serial_in_b_i;
    next_s.sb2 = s.sb1;
    line = s.pinsel ? s.sb2 : s.sa2; // RQ21
    next_s.rx_prev = line;

    // Bus: answer one cycle after the request, then drop for a cycle.
    req        = wb_cyc_i & wb_stb_i & ~s.ack;
    wr         = req & wb_we_i & wb_sel_i[0];
    blk        = ~s.pen;
    d          = wb_dat_i[7:0];
    next_s.ack = req;

    // Reads: the gated registers answer zero while the port is off.
    next_s.rdat = NBS_RST_BYTE;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        NBS_IDX_CTRL: next_s.rdat = {s.mode, s.mpe, s.pen, s.tb8, s.rb8, s.ti, s.ri}; // RQ24
        NBS_IDX_BUF:  next_s.rdat = blk ? NBS_RST_BYTE : s.rbuf;
        NBS_IDX_PWR:  next_s.rdat = blk ? NBS_RST_BYTE : {s.rate_double, 7'h00};
        NBS_IDX_RELL: next_s.rdat = blk ? NBS_RST_BYTE : s.rel[7:0];
        NBS_IDX_RELH: next_s.rdat = blk ? NBS_RST_BYTE : {6'h00, s.rel[9:8]};
        NBS_IDX_CTL2: next_s.rdat = blk ? NBS_RST_BYTE : {s.src, 6'h00, s.pinsel};
        NBS_IDX_IEN:  next_s.rdat = {s.ie_g, 1'b0, s.ie_rx, s.ie_tx, 4'h0};
        NBS_IDX_OD:   next_s.rdat = {4'h0, s.od};
        default:      next_s.rdat = NBS_RST_BYTE;
      endcase
    end

    // Writes. While off, only the enable bit and the interrupt-enable and open-drain registers can be changed.
    if (wr) begin
      unique case (wb_adr_i)
        NBS_IDX_CTRL: begin
          next_s.pen = d[NBS_B_PEN];
          if (!blk) begin // RQ18
            next_s.mode = nbs_mode_e'({d[NBS_B_MODE_HI], d[NBS_B_MODE_LO]}); // RQ26
            next_s.mpe  = d[NBS_B_MPE];
            next_s.tb8  = d[NBS_B_TB8];
            next_s.rb8  = d[NBS_B_RB8];
            next_s.ti   = d[NBS_B_TI];
            next_s.ri   = d[NBS_B_RI];
          end
        end
        NBS_IDX_BUF: begin
          // A write while a frame is in flight is dropped.
          if (!blk && !s.tx_busy) begin // RQ4
            next_s.tx_busy = 1'b1;
            next_s.tx_bit  = 4'h0;
            next_s.tx_tk   = 4'h0;
            if (s.mode == NBS_SHIFT) begin
              next_s.tx_sh = {3'b111, d};
            end else if (s.mode == NBS_VAR8) begin
              next_s.tx_sh = {2'b11, d, 1'b0};
            end else begin
              next_s.tx_sh = {1'b1, s.tb8, d, 1'b0}; // RQ3
            end
          end
        end
        NBS_IDX_PWR:  if (!blk) next_s.rate_double = d[NBS_B_RATE_DOUBLE];
        NBS_IDX_RELL: if (!blk) next_s.rel[7:0] = d;
        NBS_IDX_RELH: if (!blk) next_s.rel[9:8] = d[1:0];
        NBS_IDX_CTL2: begin
          if (!blk) begin
            next_s.src    = d[NBS_B_SRC];
            next_s.pinsel = d[NBS_B_PINSEL];
          end
        end
        NBS_IDX_IEN: begin
          next_s.ie_g  = d[NBS_B_IE_G];
          next_s.ie_rx = d[NBS_B_IE_RX];
          next_s.ie_tx = d[NBS_B_IE_TX];
        end
        NBS_IDX_OD:   next_s.od = d[3:0];
        default: begin
        end
      endcase
    end

    // Ticks per bit: sixteen in the async modes, one in shift mode.
    tpb = (s.mode == NBS_SHIFT) ? 4'h0 : NBS_TICK_LAST;

    // Transmitter. Flag sets below come after the software write above,
    // so a set in the same cycle as a clear wins.
    if (s.tx_busy && tick) begin
      if (s.tx_tk == tpb) begin
        next_s.tx_tk = 4'h0;
        if (s.tx_bit == last_bit(s.mode)) begin
          next_s.tx_busy = 1'b0;
          if (s.mode == NBS_SHIFT) begin
            next_s.ti = 1'b1;
          end
        end else begin
          next_s.tx_bit = s.tx_bit + 4'h1;
          next_s.tx_sh  = {1'b1, s.tx_sh[10:1]}; // RQ1
          if (s.mode != NBS_SHIFT && s.tx_bit + 4'h1 == last_bit(s.mode)) begin
            next_s.ti = 1'b1; // RQ5 RQ20
          end
        end
      end else begin
        next_s.tx_tk = s.tx_tk + 4'h1;
      end
    end

    // Receiver. Shift-mode reception is not provided.
    unique case (s.rx_st)
      NBS_RX_IDLE: begin
        if (s.pen && s.mode != NBS_SHIFT && s.rx_prev && !line) begin // RQ6
          next_s.rx_st  = NBS_RX_RUN;
          next_s.rx_bit = 4'h0;
          next_s.rx_tk  = 4'h0;
        end
      end
      NBS_RX_RUN: begin
        if (tick) begin
          next_s.rx_tk = (s.rx_tk == NBS_TICK_LAST) ? 4'h0 : s.rx_tk + 4'h1;
          if (s.rx_tk == NBS_TICK_LAST) begin
            next_s.rx_bit = s.rx_bit + 4'h1;
          end
          if (s.rx_tk == NBS_TICK_MID) begin
            if (s.rx_bit == 4'h0) begin
              // A start bit that is high again at mid-bit was a glitch.
              if (line) begin
                next_s.rx_st = NBS_RX_IDLE;
              end
            end else if (s.rx_bit == last_bit(s.mode)) begin
              // Middle of the stop bit: hand over the frame.
              next_s.rx_st = NBS_RX_IDLE;
              if (s.mode == NBS_VAR8) begin
                ninth       = line;
                next_s.rbuf = s.rx_sh[8:1];
              end else begin
                ninth       = s.rx_sh[8];
                next_s.rbuf = s.rx_sh[7:0]; // RQ8
              end
              next_s.rb8 = ninth; // RQ8
              if (!(s.mpe && s.mode[1] && !ninth)) begin // RQ15
                next_s.ri = 1'b1; // RQ7 RQ20
              end
            end else begin
              next_s.rx_sh = {line, s.rx_sh[8:1]}; // RQ1
            end
          end
        end
      end
    endcase

    // Port off: clocks halted, frames abandoned.
    if (!s.pen) begin
      next_s.tx_busy = 1'b0; // RQ18
      next_s.rx_st   = NBS_RX_IDLE;
    end

    // Pins: the transmit pin is only ever pulled low.
    next_s.out_a_low = next_s.tx_busy & ~next_s.tx_sh[0] & ~next_s.pinsel; // RQ25 RQ21
    next_s.out_b_low = next_s.tx_busy & ~next_s.tx_sh[0] & next_s.pinsel;

    // Interrupt requests to the external controller.
    next_s.rx_req = next_s.ri & next_s.ie_rx & next_s.ie_g;
    next_s.tx_req = next_s.ti & next_s.ie_tx & next_s.ie_g;
  end

  // -------------------------------------------------------------------
  // State register.
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s         <= '0;
      s.rx_st   <= NBS_RX_IDLE;
      s.rel     <= NBS_RST_REL;
      s.rbuf    <= NBS_RST_BYTE;
      s.tx_sh   <= '1;
      s.sa1     <= 1'b1;
      s.sa2     <= 1'b1;
      s.sb1     <= 1'b1;
      s.sb2     <= 1'b1;
      s.rx_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // -------------------------------------------------------------------
  // Outputs, all straight from flip-flops.
  // -------------------------------------------------------------------
  assign wb_dat_o           = {24'h000000, s.rdat};
  assign wb_ack_o           = s.ack;
  assign serial_out_a_low_o = s.out_a_low;
  assign serial_out_b_low_o = s.out_b_low;
  assign open_drain_sel_o   = s.od;
  assign rx_irq_req_o       = s.rx_req;
  assign tx_irq_req_o       = s.tx_req;

endmodule

`default_nettype wire

// *** tb/nbs_checker.sv ***
// Bus and pin timing checks for the nine-bit serial port.
// Assumes it is bound to every instance of the port and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module nbs_checker
  import nbs_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:2]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        timer_ovf_i,
  input wire logic        serial_in_a_i,
  input wire logic        serial_in_b_i,
  input wire logic        serial_out_a_low_o,
  input wire logic        serial_out_b_low_o,
  input wire logic [3:0]  open_drain_sel_o,
  input wire logic        rx_irq_req_o,
  input wire logic        tx_irq_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A request is taken only while ack is low; an open-drain write counts at its ack.
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_od_wr; wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == NBS_IDX_OD; endsequence
  a_ack_next: assert property (s_take |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read upper bits set");
  a_od_follows_write: assert property (s_od_wr |-> ##2 open_drain_sel_o == $past(wb_dat_i[3:0], 2))
    else $error("open-drain copy wrong");
  a_pairs_exclusive: assert property (!(serial_out_a_low_o && serial_out_b_low_o))
    else $error("both pins driven");
  a_bit_min_width: assert property ($rose(serial_out_a_low_o) |=> serial_out_a_low_o [*8])
    else $error("low bit too short");
  // Reset must silence every output but the read data whatever the bus does.
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !serial_out_a_low_o
    && !serial_out_b_low_o && !rx_irq_req_o && !tx_irq_req_o && open_drain_sel_o == 4'h0)
    else $error("outputs active after reset");
endmodule
bind nbs_serial_port nbs_checker nbs_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_ovf_i(timer_ovf_i),
  .serial_in_a_i(serial_in_a_i), .serial_in_b_i(serial_in_b_i),
  .serial_out_a_low_o(serial_out_a_low_o), .serial_out_b_low_o(serial_out_b_low_o),
  .open_drain_sel_o(open_drain_sel_o), .rx_irq_req_o(rx_irq_req_o),
  .tx_irq_req_o(tx_irq_req_o));
`default_nettype wire

// *** tb/nbs_far_model.sv ***
// Far serial device: sends nine-bit frames and records the frames it hears.
// Assumes the bench gives the bit period in clock cycles.
`timescale 1ns/10ps
`default_nettype none
module nbs_far_model (
  input  wire logic        clk_i,
  input  wire logic        tx_wire_i,
  input  wire logic [31:0] bit_cycles_i,
  output logic             rx_line_o
);
  logic [9:0] rx_q[$];  // Heard frames as stop, ninth bit, byte.
  logic [9:0] sh;       // Frame being assembled.
  initial rx_line_o = 1'b1;  // The line rests high between frames.
  // Start bit, nine data bits least significant first, then the stop bit.
  task automatic send(input logic [8:0] v);
    logic [10:0] fr;
    fr = {1'b1, v, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line_o <= fr[i];
      repeat (bit_cycles_i) @(posedge clk_i);
    end
  endtask
  // Each bit is sampled in its middle, timed from the falling start edge.
  always begin
    @(negedge tx_wire_i);
    repeat (bit_cycles_i / 2) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      repeat (bit_cycles_i) @(posedge clk_i);
      sh[i] = tx_wire_i;
    end
    rx_q.push_back(sh);
  end
endmodule
`default_nettype wire

// *** tb/nbs_serial_port_tb_top.sv ***
// Self-checking bench of the nine-bit serial port.
// Assumes the checker binds itself and the far model sits on the serial lines.
`timescale 1ns/10ps
`default_nettype none
module nbs_serial_port_tb_top;
  import nbs_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ovf = 0, pb = 0;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] dat = 0, rd, q;
  logic        ack, a_lo, b_lo, rxl, irq_r, irq_t;
  int          seed = 32'hA410, miscompares = 0, n_tests = 0, fb = 64, oc = 0, cn = 0, t;
  logic [8:0]  d;
  logic [7:0]  regs[9] = '{NBS_IDX_PWR, NBS_IDX_CTRL, NBS_IDX_BUF, NBS_IDX_IEN,
                           NBS_IDX_RELL, NBS_IDX_RELH, NBS_IDX_CTL2, NBS_IDX_OD, 8'h10};
  always #5 clk_i = ~clk_i;
  // Overflow every fifth cycle keeps the clock above four times its rate.
  always @(posedge clk_i) begin
    oc <= (oc == 4) ? 0 : oc + 1;
    ovf <= (oc == 4);
    cn <= cn + 1;
  end
  nbs_serial_port nbs_serial_port_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .timer_ovf_i(ovf), .serial_in_a_i(pb | rxl), .serial_in_b_i(!pb | rxl),
    .serial_out_a_low_o(a_lo), .serial_out_b_low_o(b_lo), .open_drain_sel_o(),
    .rx_irq_req_o(irq_r), .tx_irq_req_o(irq_t));
  // The pin latch is preset high, so the wire is the inverse of pull-low.
  nbs_far_model nbs_far_model_inst (.clk_i(clk_i), .tx_wire_i(pb ? !b_lo : !a_lo),
    .bit_cycles_i(fb), .rx_line_o(rxl));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One classic cycle; the answer is taken at the edge that shows ack.
  task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= idx;
    sel <= 4'($random(seed)) | 4'h1;
    dat <= {24'($random(seed)), v};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = rd;
    chk("bus wait", 2, n);
    cyc <= 0;
    stb <= 0;
  endtask
  // Polls the control register until a done flag shows or the limit runs out.
  task automatic wait_flag(input int b, input int lim);
    int t0;
    t0 = cn;
    do xfer(NBS_IDX_CTRL, 0, 0); while (q[b] !== 1'b1 && cn - t0 < lim);
    t = cn - t0;
  endtask
  task automatic tx_frame(input logic [7:0] ctl);
    d = 9'($random(seed));
    xfer(NBS_IDX_CTRL, 1, ctl | {4'h0, d[8], 3'h0});
    xfer(NBS_IDX_BUF, 1, d[7:0]);
    wait_flag(1, 12 * fb);
    chk("tx done time", 1, t >= 10 * fb - fb / 16 - 2 && t <= 10 * fb + 6);
    repeat (fb) @(posedge clk_i);
    chk("tx frame", {1'b1, d}, nbs_far_model_inst.rx_q.pop_front());
  endtask
  task automatic rx_frame(input logic [8:0] v, input logic fl);
    fork nbs_far_model_inst.send(v); join_none
    wait_flag(0, 12 * fb);
    chk("rx flag", fl, q[0]);
    if (fl) chk("rx time", 1, t >= 21 * fb / 2 - 2 && t <= 21 * fb / 2 + fb / 16 + 12);
    repeat (fb) @(posedge clk_i);
    xfer(NBS_IDX_BUF, 0, 0);
    chk("rx byte", v[7:0], q);
    xfer(NBS_IDX_CTRL, 0, 0);
    chk("rx ninth", v[8], q[2]);
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    foreach (regs[i]) if (i inside {0, 2, 4, 5, 6}) xfer(regs[i], 1, 8'hFF);
    foreach (regs[i]) begin
      xfer(regs[i], 0, 0);
      chk("reset value", 0, q);
    end
    $display("test register reset done");
    xfer(NBS_IDX_OD, 1, 8'h06);
    xfer(NBS_IDX_CTRL, 1, 8'h10);
    xfer(NBS_IDX_IEN, 1, 8'hB0);
    for (int s = 0; s < 2; s++) begin
      xfer(NBS_IDX_PWR, 1, 8'(s << 7));
      fb = 64 >> s;
      tx_frame(8'h90);
      chk("tx irq", 1, irq_t);
      rx_frame(9'($random(seed)), 1);
      chk("rx irq", 1, irq_r);
    end
    $display("test fixed rate done");
    xfer(NBS_IDX_IEN, 1, 8'h00);
    xfer(NBS_IDX_CTRL, 0, 0);
    chk("rx flag kept", 1, q[0]);
    chk("irq masked", 0, irq_r);
    // Address frame, then data that only flags once the slave clears the mode.
    for (int k = 0; k < 3; k++) begin
      xfer(NBS_IDX_CTRL, 1, k < 2 ? 8'hB0 : 8'h90);
      rx_frame({k == 0, 8'($random(seed))}, k != 1);
    end
    $display("test multiprocessor done");
    xfer(NBS_IDX_RELL, 1, 8'hFE);
    xfer(NBS_IDX_RELH, 1, 8'h03);
    for (int c = 0; c < 2; c++) begin
      pb <= 1'(c);
      xfer(NBS_IDX_CTL2, 1, c ? 8'h01 : 8'h80);
      xfer(NBS_IDX_PWR, 1, 8'(c << 7));
      fb = c ? 80 : 128;
      tx_frame(8'hD0);
      rx_frame(9'($random(seed)), 1);
    end
    $display("test variable rate done");
    finish_test();
  end
endmodule
`default_nettype wire
